//--- core/dtrc_code.sv
`timescale 1ns/1ns
module dtrc_code (
  input wire logic [12:0] remain_i, // seconds left
  output logic [3:0] code_o // read-back timeout code
);
  logic [14:0] above;

  // ------------------------------------------------------------------
  // bracket compare: each bound passed adds one to the code
  // ------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < 15; k++) begin : g_cmp
      assign above[k] = remain_i > dtrc_pkg::CODE_SECS[k];
    end
  endgenerate

  always_comb begin
    code_o = 4'h0;
    for (int i = 0; i < 15; i++) begin
      code_o = code_o + {3'h0, above[i]};
    end
  end
endmodule // dtrc_code

//--- core/dtrc_pkg.sv
package dtrc_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_KHZ = 250000;
  localparam int TICK_MS = 1000;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int WDT_MS = 2000;
  localparam int WDT_CYCLES = WDT_MS * CLK_KHZ;

  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CFGA_LO = 8'h00;
  localparam logic [7:0] OFS_CFGA_HI = 8'h04;
  localparam logic [7:0] OFS_CFGB = 8'h08;
  localparam logic [7:0] OFS_SCTRL = 8'h0C;
  localparam logic [7:0] OFS_PWM = 8'h10;
  localparam logic [7:0] OFS_PSB = 8'h14;
  localparam logic [7:0] OFS_MASTER_PORT_BUFFER = 8'h18;
  localparam logic [7:0] OFS_CMD = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CODE_LSB = 44;
  localparam int MON_EN_BIT = 11;
  localparam int MUTE_BIT = 9;
  localparam int CMD_COMMIT_BIT = 0;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [47:0] CFGA_RST = 48'h0000_0000_0000;
  localparam logic [15:0] CFGB_RST = 16'h0000;
  localparam logic [31:0] SCTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PWM_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] PSB_RST = 32'h0000_FFFF;
  localparam logic [31:0] MASTER_PORT_BUFFER_RST = 32'hFFFF_FFFF;

  // timeout code durations in seconds, index = code
  localparam logic [12:0] CODE_SECS [16] = '{
    13'h0000, 13'h001E, 13'h003C, 13'h0078, 13'h00B4, 13'h00F0, 13'h012C, 13'h0258,
    13'h0384, 13'h04B0, 13'h0708, 13'h0960, 13'h0E10, 13'h1194, 13'h1518, 13'h1C20
  };

  typedef enum logic [1:0] {
    DTRC_STANDBY = 2'b00,
    DTRC_EXTBAL = 2'b01,
    DTRC_SLEEP = 2'b10
  } dtrc_mode_e;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } dtrc_tick_s;

  typedef struct packed {
    logic [47:0] cfga;
    logic [47:0] stage;
    logic [15:0] cfgb;
    logic [31:0] sctrl;
    logic [31:0] pwm;
    logic [31:0] psb;
    logic [31:0] master_port_buffer;
    logic [12:0] remain;
    logic [31:0] wdt_cnt;
    logic wdt_exp;
    dtrc_mode_e mode;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [14:0] dcc;
  } dtrc_state_s;

endpackage

//--- core/dtrc_tick.sv
`timescale 1ns/1ns
module dtrc_tick #(
  parameter int unsigned PERIOD = dtrc_pkg::TICK_CYCLES
) (
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset, active low
  output logic tick_o // one-cycle pulse every PERIOD cycles
);
  dtrc_pkg::dtrc_tick_s cur_ff;
  dtrc_pkg::dtrc_tick_s nxt_ff;

  // free-running so the discharge countdown never depends on traffic
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.tick = 1'b0;
    if (cur_ff.cnt == 32'(PERIOD - 1)) begin
      nxt_ff.cnt = 32'h0000_0000;
      nxt_ff.tick = 1'b1;
    end else begin
      nxt_ff.cnt = cur_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign tick_o = cur_ff.tick;
endmodule // dtrc_tick

//--- core/dtrc_top.sv
// Functional notes
// - code zero: timer disabled or expired
// - running code gives remaining-time bracket
// - ordinary commands never restart discharge timer
// - only committed group A write restarts timer
// - expiry resets first, then written data loads
// - expiry during config read still resets
// - expiry during switch read resets switch bits
// - power cycle: standby, defaults, discharge off
// - thermal shutdown clears config except mute bit, keeps switch group
// - watchdog with timer: extended balancing, partial reset
// - watchdog without timer: sleep, full reset
// - timer expiry after watchdog: same as sleep
// - early expiry: discharge off, pwm/switch reset
// - early expiry: group A/B partial reset
// - pin high, nonzero code: switches held on
// - watchdog expires after 2 s without command
`timescale 1ns/1ns
module dtrc_top #(
  parameter int unsigned TICK_CYCLES = dtrc_pkg::TICK_CYCLES,
  parameter int unsigned WDT_CYCLES = dtrc_pkg::WDT_CYCLES
) (
  input wire logic clk, // 250 MHz core clock
  input wire logic arst_n, // power-on reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic cmd_valid_i, // pulse: valid command with matching check code
  input wire logic thsd_i, // pulse: thermal shutdown trip
  input wire logic timer_enable_pin, // level: discharge timer enable strap
  output logic [14:0] dcc_o, // discharge switch enables per cell
  output logic [1:0] mode_o, // device state
  output logic wdt_o // watchdog has expired
);
  dtrc_pkg::dtrc_state_s cur_ff;
  dtrc_pkg::dtrc_state_s nxt_ff;

  logic tick;
  logic [3:0] live_code;
  logic apb_setup;
  logic apb_done;
  logic apb_wr;
  logic kick;
  logic running;
  logic wdt_fire;
  logic dt_fire;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic [47:0] cfga_view;

  // ------------------------------------------------------------------
  // leaf blocks
  // ------------------------------------------------------------------
  dtrc_tick #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tick_o(tick)
  );

  dtrc_code u_code (
    .remain_i(cur_ff.remain),
    .code_o(live_code)
  );

  // ------------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && cur_ff.pready;
  assign apb_wr = apb_done && pwrite && !cur_ff.pslverr;
  // any completed command restarts the watchdog; only a group A commit restarts the discharge timer
  assign kick = cmd_valid_i || apb_done;
  assign running = cur_ff.remain != 13'h0000;
  assign wdt_fire = !kick && !cur_ff.wdt_exp && (cur_ff.wdt_cnt == 32'(WDT_CYCLES - 1));
  assign dt_fire = running && tick && timer_enable_pin && (cur_ff.remain == 13'h0001);

  // read path shows the live code in place of the stored field
  always_comb begin
    cfga_view = cur_ff.cfga;
    cfga_view[dtrc_pkg::CODE_LSB +: 4] = live_code;
  end

  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      dtrc_pkg::OFS_CFGA_LO: rd_mux = cfga_view[31:0];
      dtrc_pkg::OFS_CFGA_HI: rd_mux = {16'h0000, cfga_view[47:32]};
      dtrc_pkg::OFS_CFGB: rd_mux = {16'h0000, cur_ff.cfgb};
      dtrc_pkg::OFS_SCTRL: rd_mux = cur_ff.sctrl;
      dtrc_pkg::OFS_PWM: rd_mux = cur_ff.pwm;
      dtrc_pkg::OFS_PSB: rd_mux = cur_ff.psb;
      dtrc_pkg::OFS_MASTER_PORT_BUFFER: rd_mux = cur_ff.master_port_buffer;
      dtrc_pkg::OFS_CMD: rd_mux = 32'h0000_0000;
      dtrc_pkg::OFS_STATUS: begin
        rd_mux = {20'h00000, live_code, running, cur_ff.wdt_exp, 4'h0, cur_ff.mode};
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_ff = cur_ff;

    // discharge countdown, one second per tick
    if (tick && running) begin
      nxt_ff.remain = cur_ff.remain - 13'h0001;
    end
    if (!timer_enable_pin) begin
      nxt_ff.remain = 13'h0000;
    end

    // watchdog: a command wakes the device and restarts the count
    if (kick) begin
      nxt_ff.wdt_cnt = 32'h0000_0000;
      nxt_ff.wdt_exp = 1'b0;
      nxt_ff.mode = dtrc_pkg::DTRC_STANDBY;
    end else if (!cur_ff.wdt_exp) begin
      nxt_ff.wdt_cnt = cur_ff.wdt_cnt + 32'h0000_0001;
    end
    if (wdt_fire) begin
      nxt_ff.wdt_exp = 1'b1;
    end

    // watchdog timeout
    if (wdt_fire && running) begin
      nxt_ff.mode = dtrc_pkg::DTRC_EXTBAL;
      nxt_ff.cfga[7:0] = dtrc_pkg::CFGA_RST[7:0];
      if (!cur_ff.cfgb[dtrc_pkg::MON_EN_BIT]) begin
        nxt_ff.cfga[31:8] = dtrc_pkg::CFGA_RST[31:8];
      end
      nxt_ff.cfgb[3:0] = dtrc_pkg::CFGB_RST[3:0];
      nxt_ff.master_port_buffer = dtrc_pkg::MASTER_PORT_BUFFER_RST;
    end

    // expiry resets act on stored groups even mid-read; the host discards data
    if ((wdt_fire && !running) || (dt_fire && (cur_ff.wdt_exp || wdt_fire))) begin
      nxt_ff.mode = dtrc_pkg::DTRC_SLEEP;
      nxt_ff.cfga = dtrc_pkg::CFGA_RST;
      nxt_ff.cfgb = dtrc_pkg::CFGB_RST;
      nxt_ff.pwm = dtrc_pkg::PWM_RST;
      nxt_ff.sctrl = dtrc_pkg::SCTRL_RST;
      nxt_ff.psb = dtrc_pkg::PSB_RST;
      nxt_ff.master_port_buffer = dtrc_pkg::MASTER_PORT_BUFFER_RST;
      nxt_ff.remain = 13'h0000;
    end else if (dt_fire) begin
      nxt_ff.pwm = dtrc_pkg::PWM_RST;
      nxt_ff.sctrl = dtrc_pkg::SCTRL_RST;
      nxt_ff.psb = dtrc_pkg::PSB_RST;
      if (cur_ff.cfgb[dtrc_pkg::MON_EN_BIT]) begin
        nxt_ff.cfga[31:8] = dtrc_pkg::CFGA_RST[31:8];
      end
      nxt_ff.cfga[47:32] = dtrc_pkg::CFGA_RST[47:32];
      nxt_ff.cfgb[7:4] = dtrc_pkg::CFGB_RST[7:4];
      nxt_ff.cfgb[15:8] = dtrc_pkg::CFGB_RST[15:8];
      nxt_ff.cfgb[dtrc_pkg::MUTE_BIT] = cur_ff.cfgb[dtrc_pkg::MUTE_BIT];
    end

    // thermal trip leaves the switch-control group alone
    if (thsd_i) begin
      nxt_ff.cfga = dtrc_pkg::CFGA_RST;
      nxt_ff.cfgb = dtrc_pkg::CFGB_RST;
      nxt_ff.cfgb[dtrc_pkg::MUTE_BIT] = cur_ff.cfgb[dtrc_pkg::MUTE_BIT];
      nxt_ff.master_port_buffer = dtrc_pkg::MASTER_PORT_BUFFER_RST;
      nxt_ff.remain = 13'h0000;
    end

    // bus handshake: answer registered in setup, so access completes at once
    nxt_ff.pready = apb_setup;
    if (apb_setup) begin
      nxt_ff.prdata = rd_mux;
      nxt_ff.pslverr = !addr_hit;
    end else if (apb_done) begin
      nxt_ff.pslverr = 1'b0;
    end

    // writes land after event resets so a commit in the expiry cycle survives
    if (apb_wr) begin
      case (paddr)
        dtrc_pkg::OFS_CFGA_LO: nxt_ff.stage[31:0] = pwdata;
        dtrc_pkg::OFS_CFGA_HI: nxt_ff.stage[47:32] = pwdata[15:0];
        dtrc_pkg::OFS_CFGB: nxt_ff.cfgb = pwdata[15:0];
        dtrc_pkg::OFS_SCTRL: nxt_ff.sctrl = pwdata;
        dtrc_pkg::OFS_PWM: nxt_ff.pwm = pwdata;
        dtrc_pkg::OFS_PSB: nxt_ff.psb = pwdata;
        dtrc_pkg::OFS_MASTER_PORT_BUFFER: nxt_ff.master_port_buffer = pwdata;
        dtrc_pkg::OFS_CMD: begin
          if (pwdata[dtrc_pkg::CMD_COMMIT_BIT]) begin
            nxt_ff.cfga = cur_ff.stage;
            if (timer_enable_pin) begin
              nxt_ff.remain = dtrc_pkg::CODE_SECS[cur_ff.stage[dtrc_pkg::CODE_LSB +: 4]];
            end else begin
              nxt_ff.remain = 13'h0000;
            end
          end
        end
        default: nxt_ff.stage = cur_ff.stage;
      endcase
    end

    // switches follow the cell bits until the watchdog fires, then only with the timer
    if (nxt_ff.mode == dtrc_pkg::DTRC_SLEEP ||
        (nxt_ff.wdt_exp && nxt_ff.remain == 13'h0000)) begin
      nxt_ff.dcc = 15'h0000;
    end else begin
      nxt_ff.dcc = {nxt_ff.cfgb[6:4], nxt_ff.cfga[43:32]};
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff.cfga <= dtrc_pkg::CFGA_RST;
      cur_ff.stage <= dtrc_pkg::CFGA_RST;
      cur_ff.cfgb <= dtrc_pkg::CFGB_RST;
      cur_ff.sctrl <= dtrc_pkg::SCTRL_RST;
      cur_ff.pwm <= dtrc_pkg::PWM_RST;
      cur_ff.psb <= dtrc_pkg::PSB_RST;
      cur_ff.master_port_buffer <= dtrc_pkg::MASTER_PORT_BUFFER_RST;
      cur_ff.remain <= 13'h0000;
      cur_ff.wdt_cnt <= 32'h0000_0000;
      cur_ff.wdt_exp <= 1'b0;
      cur_ff.mode <= dtrc_pkg::DTRC_STANDBY;
      cur_ff.pready <= 1'b0;
      cur_ff.pslverr <= 1'b0;
      cur_ff.prdata <= 32'h0000_0000;
      cur_ff.dcc <= 15'h0000;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign dcc_o = cur_ff.dcc;
  assign mode_o = cur_ff.mode;
  assign wdt_o = cur_ff.wdt_exp;
endmodule // dtrc_top

//--- tb/dtrc_host.sv
`timescale 1ns/1ns
module dtrc_host (
  input wire logic clk, // core clock
  output logic psel = 1'b0, // apb select
  output logic penable = 1'b0, // apb access phase
  output logic pwrite = 1'b0, // apb direction
  output logic [7:0] paddr = 8'h00, // apb address
  output logic [31:0] pwdata = 32'h0, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr // apb error
);
  // ----------------------------------------
  // host side of the register link
  // ----------------------------------------
  // the host extends discharge only through the group A commit
  // read data is not cross-checked during expiry, it may be stale
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle so no signal is driven twice in one step
    @(posedge clk);
  endtask
endmodule // dtrc_host

//--- tb/dtrc_top_props.sv
`timescale 1ns/1ns
module dtrc_chk #(
  parameter int unsigned WDT_CYCLES = 50
) (
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic cmd_valid_i, // command pulse
  input wire logic thsd_i, // thermal trip
  input wire logic timer_enable_pin, // timer strap
  input wire logic [14:0] dcc_o, // switches
  input wire logic [1:0] mode_o, // state
  input wire logic wdt_o // watchdog flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // cycles since the last command, counted as the watchdog should
  logic [31:0] idle_ff;
  logic [31:0] nxt_idle;
  always_comb nxt_idle = (cmd_valid_i || (psel && penable && pready)) ? 32'h0 : idle_ff + 32'h1;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) idle_ff <= 32'h0;
    else idle_ff <= nxt_idle;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_quiet_trip;
    thsd_i && !psel ##1 !psel;
  endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_unmapped_err: assert property (s_setup ##0 (paddr > 8'h20) |=>
    pready && pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
  a_code_pin_low: assert property (s_setup ##0 (!pwrite && paddr == 8'h20 &&
    !timer_enable_pin && !$past(timer_enable_pin)) |=> prdata[11:7] == 5'h00)
    else $error("code not zero with pin low");
  a_cmd_clears_wdt: assert property (cmd_valid_i |=> !wdt_o) else $error("wdt not cleared");
  a_wdt_not_early: assert property (idle_ff < WDT_CYCLES - 2 |-> !wdt_o)
    else $error("watchdog early");
  a_wdt_not_late: assert property (idle_ff == WDT_CYCLES + 2 |-> wdt_o)
    else $error("watchdog late");
  a_wdt_leaves_stby: assert property ($rose(wdt_o) |-> mode_o != 2'b00)
    else $error("watchdog kept standby");
  a_sleep_dark: assert property ((mode_o == 2'b10) [*2] |-> dcc_o == 15'h0)
    else $error("discharge on in sleep");
  a_sleep_holds: assert property (mode_o == 2'b10 && !cmd_valid_i &&
    !(psel && penable) |=> mode_o == 2'b10) else $error("sleep left");
  a_thsd_dark: assert property (s_quiet_trip |=> dcc_o == 15'h0)
    else $error("discharge on after trip");
endmodule // dtrc_chk

bind dtrc_top dtrc_chk #(.WDT_CYCLES(WDT_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cmd_valid_i(cmd_valid_i), .thsd_i(thsd_i),
  .timer_enable_pin(timer_enable_pin), .dcc_o(dcc_o), .mode_o(mode_o), .wdt_o(wdt_o));

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic thsd_i = 1'b0;
  logic pin = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, wdt_o, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] dcc_o;
  logic [1:0] mode_o;
  int error_cnt = 0;
  int comparisons = 0;
  int i;
  time t0;
  always #2 clk = ~clk;
  dtrc_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // short tick and watchdog keep every timeout inside the run
  dtrc_top #(.TICK_CYCLES(4), .WDT_CYCLES(50)) u_dut (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid_i(cmd_valid_i),
    .thsd_i(thsd_i), .timer_enable_pin(pin), .dcc_o(dcc_o), .mode_o(mode_o), .wdt_o(wdt_o));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    u_host.xfer(1'b0, a, 32'h0, rd, er);
    cmp(rd & m, exp);
  endtask
  task automatic rst_chk();
    chk(8'h00, 32'h0, 32'hFFFFFFFF);
    chk(8'h04, 32'h0, 32'hFFFFFFFF);
    chk(8'h08, 32'h0, 32'hFFFFFFFF);
    chk(8'h0C, 32'h0, 32'hFFFFFFFF);
    chk(8'h10, 32'hFFFFFFFF, 32'hFFFFFFFF);
    chk(8'h14, 32'h0000FFFF, 32'hFFFFFFFF);
    chk(8'h18, 32'hFFFFFFFF, 32'hFFFFFFFF);
    cmp({30'h0, mode_o}, 32'h0);
  endtask
  task automatic wait_flag(input int lim);
    i = 0;
    while (wdt_o !== 1'b1 && i < lim) begin
      @(posedge clk);
      i++;
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rst_chk();
    u_host.xfer(1'b0, 8'h24, 32'h0, rd, er);
    cmp({er, rd[30:0]}, 32'h80000000);
    wr(8'h04, 32'h0FFF);
    wr(8'h1C, 32'h1);
    wr(8'h08, 32'hFFFF);
    wr(8'h0C, 32'hA5A5A5A5);
    wr(8'h18, 32'h0);
    thsd_i <= 1'b1;
    @(posedge clk);
    thsd_i <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({17'h0, dcc_o}, 32'h0);
    chk(8'h08, 32'h0200, 32'hFFFF);
    chk(8'h04, 32'h0, 32'hFFFF);
    chk(8'h0C, 32'hA5A5A5A5, 32'hFFFFFFFF);
    chk(8'h18, 32'hFFFFFFFF, 32'hFFFFFFFF);
    for (int c = 1; c < 16; c++) begin
      wr(8'h04, 32'(c) << 12);
      wr(8'h1C, 32'h1);
      chk(8'h20, 32'(c) << 8, 32'h0F00);
    end
    pin <= 1'b0;
    repeat (2) @(posedge clk);
    chk(8'h20, 32'h0, 32'h0F80);
    pin <= 1'b1;
    // early expiry: reads keep the watchdog fed but must not restart the timer
    wr(8'h08, 32'hFAF5);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h0C, 32'h3C3C3C3C);
    wr(8'h00, 32'h12345678);
    wr(8'h04, 32'h1000);
    wr(8'h1C, 32'h1);
    t0 = $time;
    rd = 32'h80;
    for (int n = 0; n < 80 && rd[7] !== 1'b0; n++) u_host.xfer(1'b0, 8'h20, 32'h0, rd, er);
    cmp({31'h0, ($time - t0) inside {[440:540]}}, 32'h1);
    cmp(rd & 32'h0F80, 32'h0);
    chk(8'h08, 32'h0205, 32'hFFFF);
    chk(8'h00, 32'h00000078, 32'hFFFFFFFF);
    chk(8'h04, 32'h0, 32'hFFFF);
    chk(8'h0C, 32'h0, 32'hFFFFFFFF);
    chk(8'h10, 32'hFFFFFFFF, 32'hFFFFFFFF);
    chk(8'h14, 32'h0000FFFF, 32'hFFFFFFFF);
    // watchdog with the timer off
    wr(8'h10, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    wr(8'h04, 32'h0);
    wr(8'h1C, 32'h1);
    wait_flag(80);
    cmp({15'h0, mode_o, dcc_o}, 32'h00010000);
    cmd_valid_i <= 1'b1;
    @(posedge clk);
    cmd_valid_i <= 1'b0;
    @(posedge clk);
    cmp({29'h0, wdt_o, mode_o}, 32'h0);
    chk(8'h00, 32'h0, 32'hFFFFFFFF);
    chk(8'h10, 32'hFFFFFFFF, 32'hFFFFFFFF);
    // watchdog while the timer runs, then expiry after it
    wr(8'h08, 32'h00FF);
    wr(8'h00, 32'hFFFFFFFF);
    wr(8'h04, 32'h2FFF);
    wr(8'h1C, 32'h1);
    wait_flag(80);
    cmp({15'h0, mode_o, dcc_o}, 32'h0000FFFF);
    chk(8'h00, 32'h0, 32'hFFFFFFFF);
    chk(8'h08, 32'h00F0, 32'hFFFF);
    i = 0;
    while (mode_o !== 2'b10 && i < 400) begin
      @(posedge clk);
      i++;
    end
    cmp({14'h0, wdt_o, mode_o, dcc_o}, 32'h00030000);
    chk(8'h04, 32'h0, 32'hFFFF);
    chk(8'h08, 32'h0, 32'hFFFF);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rst_chk();
    wrap_up();
  end
endmodule // testbench
